/* rtl/fer_pkg.sv */
// Shared constants for the fault event recorder
package fer_pkg;

	// Event counters: index 0 is the input under-voltage shutdown counter
	localparam int NUM_EVT = 10;
	localparam int NUM_CRIT = 6;
	localparam int CNT_W = 4;
	localparam int CYC_W = 16;

	// Stored record geometry
	localparam int REC_BYTES = 38;
	localparam int NUM_SLOTS = 5;
	localparam int REC_BITS = REC_BYTES * 8;
	localparam int LOG_BYTES = NUM_SLOTS * REC_BYTES;
	localparam int SLOT_CNT_W = 3;

	// Byte offsets of the fields inside one record
	localparam int REC_OFS_ONTIME = 0;
	localparam int REC_OFS_RTC = 3;
	localparam int REC_OFS_AC = 7;
	localparam int REC_OFS_ENCYC = 9;
	localparam int REC_OFS_STATUS = 11;
	localparam int REC_OFS_TELEM = 17;
	localparam int REC_OFS_EVT = 33;

	// Register byte addresses
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_STATUS = 8'h04;
	localparam logic [7:0] ADR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADR_IRQ_MASK = 8'h0C;
	localparam logic [7:0] ADR_CYCLES = 8'h10;
	localparam logic [7:0] ADR_EVT_LO = 8'h14;
	localparam logic [7:0] ADR_LOG_PTR = 8'h18;
	localparam logic [7:0] ADR_LOG_DATA = 8'h1C;
	localparam logic [7:0] ADR_EVT_HI = 8'h20;

	// Field positions
	localparam int CTRL_ERASE = 0;
	localparam int CTRL_RESTORE = 1;
	localparam int IRQ_WARN = 0;
	localparam int IRQ_REC = 1;
	localparam int NUM_IRQ = 2;
	localparam int STAT_EN_ON = 8;
	localparam int STAT_PWR_OK = 9;

	// Reset values
	localparam logic [NUM_IRQ-1:0] IRQ_MASK_RST = 2'h0;
	localparam logic [7:0] LOG_PTR_RST = 8'h00;

endpackage : fer_pkg

/* rtl/fer_log_if.sv */
// Connection between the recorder core and its record store
`timescale 1ns/100ps
interface fer_log_if;
	logic push;
	logic [fer_pkg::REC_BITS-1:0] rec;
	logic erase;
	logic [7:0] rd_idx;
	logic [7:0] rd_byte;
	logic [fer_pkg::SLOT_CNT_W-1:0] count;
	logic [fer_pkg::REC_BITS-1:0] newest;

	modport store (
		input push,
		input rec,
		input erase,
		input rd_idx,
		output rd_byte,
		output count,
		output newest
	);
	modport ctl (
		output push,
		output rec,
		output erase,
		output rd_idx,
		input rd_byte,
		input count,
		input newest
	);
endinterface : fer_log_if

/* rtl/fer_sat_counter.sv */
// Saturating up-counter with parallel load
`timescale 1ns/100ps
module fer_sat_counter #(
	parameter int W = 4
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic inc,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	output logic [W-1:0] count
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} fer_sat_st_t;

	fer_sat_st_t st_r;
	fer_sat_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (load) begin
			st_nxt.cnt = load_val;
		end else if (inc && (st_r.cnt != {W{1'b1}})) begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign count = st_r.cnt;
endmodule : fer_sat_counter

/* rtl/fer_log_store.sv */
// Record store: newest record first, oldest dropped on overflow
`timescale 1ns/100ps
module fer_log_store #(
	parameter int NSLOT = fer_pkg::NUM_SLOTS
) (
	input wire logic clk_sys,
	fer_log_if.store lg
);
	localparam int RB = fer_pkg::REC_BITS;
	localparam logic [7:0] RBY = 8'(fer_pkg::REC_BYTES);

	typedef struct packed {
		logic [NSLOT-1:0][RB-1:0] slot;
		logic [fer_pkg::SLOT_CNT_W-1:0] count;
	} fer_store_st_t;

	// Stands in for non-volatile storage: not cleared by the core reset
	fer_store_st_t st_r;
	fer_store_st_t st_nxt;
	logic [7:0] sel_slot;
	logic [7:0] sel_ofs;

	always_comb begin
		st_nxt = st_r;
		if (lg.push) begin
			st_nxt.slot[0] = lg.rec;
			for (int i = 1; i < NSLOT; i++) begin
				st_nxt.slot[i] = st_r.slot[i-1];
			end
			if (lg.erase) begin
				// A shutdown record never gets lost to an erase in the same cycle
				st_nxt.count = fer_pkg::SLOT_CNT_W'(1);
			end else if (st_r.count != fer_pkg::SLOT_CNT_W'(NSLOT)) begin
				st_nxt.count = st_r.count + 1'b1;
			end
		end else if (lg.erase) begin
			st_nxt.count = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		st_r <= st_nxt;
	end

	// Byte read: slot 0 is the newest record, empty slots read zero
	always_comb begin
		sel_slot = lg.rd_idx / RBY;
		sel_ofs = lg.rd_idx % RBY;
		lg.rd_byte = 8'h00;
		for (int i = 0; i < NSLOT; i++) begin
			if ((sel_slot == 8'(i)) && (8'(i) < 8'(st_r.count))) begin
				lg.rd_byte = st_r.slot[i][int'(sel_ofs)*8 +: 8];
			end
		end
	end

	assign lg.count = st_r.count;
	assign lg.newest = st_r.slot[0];
endmodule : fer_log_store

/* rtl/fer_event_recorder.sv */
// Fault event recorder core with Wishbone register access
`timescale 1ns/100ps
module fer_event_recorder (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq,
	input wire logic main_supply_enable_n,
	input wire logic input_power_ok,
	input wire logic [fer_pkg::NUM_EVT-1:0] evt_status,
	input wire logic [15:0] status_word,
	input wire logic [7:0] status_iout,
	input wire logic [7:0] status_input,
	input wire logic [7:0] status_temp,
	input wire logic [7:0] status_fan,
	input wire logic [15:0] read_vin,
	input wire logic [15:0] read_iin,
	input wire logic [15:0] read_iout,
	input wire logic [15:0] read_temp1,
	input wire logic [15:0] read_temp2,
	input wire logic [15:0] read_fan_speed,
	input wire logic [15:0] read_pin,
	input wire logic [15:0] read_vout
);
	localparam int NE = fer_pkg::NUM_EVT;
	localparam int NC = fer_pkg::NUM_CRIT;
	localparam int CW = fer_pkg::CNT_W;
	localparam int YW = fer_pkg::CYC_W;
	localparam int NI = fer_pkg::NUM_IRQ;

	typedef struct packed {
		logic en_meta;
		logic en_sync;
		logic pwr_meta;
		logic pwr_sync;
		logic en_on_prev;
		logic pwr_prev;
		logic [NE-1:0] evt_prev;
		logic pend;
		logic pend_crit;
		logic [NI-1:0] irq_stat;
		logic [NI-1:0] irq_mask;
		logic irq;
		logic ack;
		logic [31:0] dat;
		logic [7:0] log_ptr;
		logic erase;
		logic restore;
	} fer_top_st_t;

	fer_top_st_t st_r;
	fer_top_st_t st_nxt;

	fer_log_if lg ();

	logic en_on;
	logic [NE-1:0] evt_rise;
	logic [NE-1:0] evt_inc;
	logic [NE*CW-1:0] evt_cnt;
	logic [YW-1:0] en_cyc;
	logic [YW-1:0] ac_cyc;
	logic en_cyc_inc;
	logic ac_inc;
	logic cnt_load;
	logic wb_req;
	logic wb_wr;
	logic [NI-1:0] irq_set;
	logic [NI-1:0] irq_clr;
	logic [31:0] rd_val;
	logic [fer_pkg::REC_BITS-1:0] rec_img;

	// Enable pin is active low; asserted means the main output is wanted
	assign en_on = ~st_r.en_sync;

	// New assertions only; a bit held high counts once
	assign evt_rise = evt_status & ~st_r.evt_prev;
	assign evt_inc = evt_rise;

	// Off-then-on through the enable, counted with input power present
	assign en_cyc_inc = en_on & ~st_r.en_on_prev & st_r.pwr_sync;
	// Input power returning, counted while the supply is enabled
	assign ac_inc = st_r.pwr_sync & ~st_r.pwr_prev & en_on;

	// Counters may be reloaded from the newest stored record
	assign cnt_load = st_r.restore && (lg.count != '0);

	// One saturating nibble per event type
	genvar gi;
	generate
		for (gi = 0; gi < NE; gi++) begin : g_evt
			fer_sat_counter #(
				.W(CW)
			) u_cnt (
				.clk_sys(clk_sys),
				.srst(srst),
				.inc(evt_inc[gi]),
				.load(cnt_load),
				.load_val(lg.newest[fer_pkg::REC_OFS_EVT*8 + gi*CW +: CW]),
				.count(evt_cnt[gi*CW +: CW])
			);
		end
	endgenerate

	fer_sat_counter #(
		.W(YW)
	) u_en_cyc (
		.clk_sys(clk_sys),
		.srst(srst),
		.inc(en_cyc_inc),
		.load(cnt_load),
		.load_val(lg.newest[fer_pkg::REC_OFS_ENCYC*8 +: YW]),
		.count(en_cyc)
	);

	fer_sat_counter #(
		.W(YW)
	) u_ac_cyc (
		.clk_sys(clk_sys),
		.srst(srst),
		.inc(ac_inc),
		.load(cnt_load),
		.load_val(lg.newest[fer_pkg::REC_OFS_AC*8 +: YW]),
		.count(ac_cyc)
	);

	fer_log_store #(
		.NSLOT(fer_pkg::NUM_SLOTS)
	) u_store (
		.clk_sys(clk_sys),
		.lg(lg)
	);

	// Record image, byte 0 in the low bits; on-time and clock stay zero
	always_comb begin
		rec_img = '0;
		rec_img[fer_pkg::REC_OFS_ONTIME*8 +: 24] = 24'h00_0000;
		rec_img[fer_pkg::REC_OFS_RTC*8 +: 32] = 32'h0000_0000;
		rec_img[fer_pkg::REC_OFS_AC*8 +: YW] = ac_cyc;
		rec_img[fer_pkg::REC_OFS_ENCYC*8 +: YW] = en_cyc;
		rec_img[fer_pkg::REC_OFS_STATUS*8 +: 16] = status_word;
		rec_img[fer_pkg::REC_OFS_STATUS*8+16 +: 8] = status_iout;
		rec_img[fer_pkg::REC_OFS_STATUS*8+24 +: 8] = status_input;
		rec_img[fer_pkg::REC_OFS_STATUS*8+32 +: 8] = status_temp;
		rec_img[fer_pkg::REC_OFS_STATUS*8+40 +: 8] = status_fan;
		rec_img[fer_pkg::REC_OFS_TELEM*8 +: 16] = read_vin;
		rec_img[fer_pkg::REC_OFS_TELEM*8+16 +: 16] = read_iin;
		rec_img[fer_pkg::REC_OFS_TELEM*8+32 +: 16] = read_iout;
		rec_img[fer_pkg::REC_OFS_TELEM*8+48 +: 16] = read_temp1;
		rec_img[fer_pkg::REC_OFS_TELEM*8+64 +: 16] = read_temp2;
		rec_img[fer_pkg::REC_OFS_TELEM*8+80 +: 16] = read_fan_speed;
		rec_img[fer_pkg::REC_OFS_TELEM*8+96 +: 16] = read_pin;
		rec_img[fer_pkg::REC_OFS_TELEM*8+112 +: 16] = read_vout;
		rec_img[fer_pkg::REC_OFS_EVT*8 +: NE*CW] = evt_cnt;
	end

	assign lg.rec = rec_img;

	// Counters already hold this event's increment when the record is taken
	assign lg.push = st_r.pend & st_r.pend_crit;
	assign lg.erase = st_r.erase;
	assign lg.rd_idx = st_r.log_ptr;

	assign wb_req = wb_cyc_i & wb_stb_i & ~st_r.ack;
	assign wb_wr = wb_req & wb_we_i;

	always_comb begin
		irq_set = '0;
		irq_set[fer_pkg::IRQ_WARN] = st_r.pend & ~st_r.pend_crit;
		irq_set[fer_pkg::IRQ_REC] = lg.push;
		irq_clr = '0;
		if (wb_wr && wb_sel_i[0] && (wb_adr_i == fer_pkg::ADR_IRQ_STAT)) begin
			irq_clr = wb_dat_i[NI-1:0];
		end
	end

	// Register read mux
	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (wb_adr_i)
			fer_pkg::ADR_STATUS: begin
				rd_val[fer_pkg::SLOT_CNT_W-1:0] = lg.count;
				rd_val[fer_pkg::STAT_EN_ON] = en_on;
				rd_val[fer_pkg::STAT_PWR_OK] = st_r.pwr_sync;
			end
			fer_pkg::ADR_IRQ_STAT: begin
				rd_val[NI-1:0] = st_r.irq_stat;
			end
			fer_pkg::ADR_IRQ_MASK: begin
				rd_val[NI-1:0] = st_r.irq_mask;
			end
			fer_pkg::ADR_CYCLES: begin
				rd_val = {ac_cyc, en_cyc};
			end
			fer_pkg::ADR_EVT_LO: begin
				rd_val = evt_cnt[31:0];
			end
			fer_pkg::ADR_EVT_HI: begin
				rd_val[NE*CW-33:0] = evt_cnt[NE*CW-1:32];
			end
			fer_pkg::ADR_LOG_PTR: begin
				rd_val[7:0] = st_r.log_ptr;
			end
			fer_pkg::ADR_LOG_DATA: begin
				rd_val[7:0] = lg.rd_byte;
			end
			default: begin
				rd_val = 32'h0000_0000;
			end
		endcase
	end

	always_comb begin
		st_nxt = st_r;

		// Two-stage synchronisers for the pins
		st_nxt.en_meta = main_supply_enable_n;
		st_nxt.en_sync = st_r.en_meta;
		st_nxt.pwr_meta = input_power_ok;
		st_nxt.pwr_sync = st_r.pwr_meta;
		st_nxt.en_on_prev = en_on;
		st_nxt.pwr_prev = st_r.pwr_sync;

		// Event detection; a record is taken one cycle later, for critical events 0 to 5 only
		st_nxt.evt_prev = evt_status;
		st_nxt.pend = |evt_rise;
		st_nxt.pend_crit = |evt_rise[NC-1:0];

		// One-cycle command pulses
		st_nxt.erase = 1'b0;
		st_nxt.restore = 1'b0;

		// Wishbone: answer one cycle after the request is seen
		st_nxt.ack = wb_req;
		if (wb_req) begin
			st_nxt.dat = wb_we_i ? 32'h0000_0000 : rd_val;
		end

		if (wb_wr && wb_sel_i[0]) begin
			unique case (wb_adr_i)
				fer_pkg::ADR_CTRL: begin
					st_nxt.erase = wb_dat_i[fer_pkg::CTRL_ERASE];
					st_nxt.restore = wb_dat_i[fer_pkg::CTRL_RESTORE];
				end
				fer_pkg::ADR_IRQ_MASK: begin
					st_nxt.irq_mask = wb_dat_i[NI-1:0];
				end
				fer_pkg::ADR_LOG_PTR: begin
					st_nxt.log_ptr = wb_dat_i[7:0];
				end
				default: begin
					st_nxt.log_ptr = st_r.log_ptr;
				end
			endcase
		end

		// Log data read steps through the log, newest record first
		if (wb_req && !wb_we_i && (wb_adr_i == fer_pkg::ADR_LOG_DATA)) begin
			if (st_r.log_ptr >= 8'(fer_pkg::LOG_BYTES - 1)) begin
				st_nxt.log_ptr = 8'h00;
			end else begin
				st_nxt.log_ptr = st_r.log_ptr + 8'h01;
			end
		end

		// Sticky status, write one to clear; a new event wins over the clear
		st_nxt.irq_stat = (st_r.irq_stat & ~irq_clr) | irq_set;
		st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st_r <= '0;
			st_r.en_meta <= 1'b1;
			st_r.en_sync <= 1'b1;
			st_r.irq_mask <= fer_pkg::IRQ_MASK_RST;
			st_r.log_ptr <= fer_pkg::LOG_PTR_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign wb_dat_o = st_r.dat;
	assign wb_ack_o = st_r.ack;
	assign irq = st_r.irq;

endmodule : fer_event_recorder

/* tb/fer_event_recorder_asserts.sv */
// Bus and interrupt timing checks for the fault event recorder
`timescale 1ns/100ps
module fer_event_recorder_asserts (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic irq,
	input wire logic [fer_pkg::NUM_EVT-1:0] evt_status
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_ack_timely: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	a_ack_unasked: assert property (
		!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack unasked");
	a_rdata_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o)
		else $error("read data moved");
	a_write_zero: assert property (
		wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0)
		else $error("write data not zero");
	a_unmapped_zero: assert property (
		wb_ack_o && $past(wb_adr_i) > 8'h20 |-> wb_dat_o == 32'h0)
		else $error("unmapped not zero");
	a_irq_rise: assert property ($rose(irq) |->
		$past(evt_status, 2) != '0 || $past(wb_cyc_i) ||
		$past(wb_cyc_i, 2))
		else $error("irq rose alone");
	a_irq_fall: assert property (
		$fell(irq) |-> $past(wb_cyc_i) || $past(wb_cyc_i, 2))
		else $error("irq fell alone");
endmodule : fer_event_recorder_asserts

bind fer_event_recorder fer_event_recorder_asserts chk_u (.clk_sys,
	.srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
	.wb_ack_o, .irq, .evt_status);

/* tb/fer_host_model.sv */
// Management host model issuing classic Wishbone cycles
`timescale 1ns/100ps
module fer_host_model (
	input wire logic clk_sys,
	output logic wb_cyc,
	output logic wb_stb,
	output logic wb_we,
	output logic [7:0] wb_adr,
	output logic [3:0] wb_sel,
	output logic [31:0] wb_wdat,
	input wire logic wb_ack,
	input wire logic [31:0] wb_rdat
);
	initial begin
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_sel = 4'h0;
		wb_wdat = 32'h0;
	end

	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_sys);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_sel <= 4'hF;
		wb_wdat <= d;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		q = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (wb_ack !== 1'b1) begin
			tb.fail_count++;
			tb.final_report();
		end
	endtask : xfer
endmodule : fer_host_model

/* tb/tb.sv */
// Self-checking bench for the fault event recorder
`timescale 1ns/100ps
module tb;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
	logic [7:0] wb_adr_i, e;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rdat;
	logic main_supply_enable_n = 1'b1;
	logic input_power_ok = 1'b0;
	logic [fer_pkg::NUM_EVT-1:0] evt_status = '0;
	logic [15:0] status_word, read_vin, read_iin, read_iout, read_temp1;
	logic [15:0] read_temp2, read_fan_speed, read_pin, read_vout;
	logic [7:0] status_iout, status_input, status_temp, status_fan;
	logic [175:0] tele;
	logic [1:0] pins [10] = '{2'b00, 2'b10, 2'b11, 2'b01, 2'b00,
		2'b01, 2'b11, 2'b10, 2'b11, 2'b01};
	logic [7:0] cnt_byte [33:37] = '{8'h2F, 8'h43, 8'h65, 8'h0, 8'h0};
	int pulses [10] = '{17, 2, 3, 4, 5, 6, 7, 8, 9, 10};
	int fail_count = 0;
	int num_checks = 0;

	// Snapshot inputs laid out so that record byte k carries value k
	assign {read_vout, read_pin, read_fan_speed, read_temp2, read_temp1,
		read_iout, read_iin, read_vin, status_fan, status_temp,
		status_input, status_iout, status_word} = tele;

	always #2.5 clk_sys = ~clk_sys;

	fer_event_recorder dut_u (.clk_sys, .srst, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.irq, .main_supply_enable_n, .input_power_ok, .evt_status,
		.status_word, .status_iout, .status_input, .status_temp,
		.status_fan, .read_vin, .read_iin, .read_iout, .read_temp1,
		.read_temp2, .read_fan_speed, .read_pin, .read_vout);
	fer_host_model host_u (.clk_sys, .wb_cyc(wb_cyc_i),
		.wb_stb(wb_stb_i), .wb_we(wb_we_i), .wb_adr(wb_adr_i),
		.wb_sel(wb_sel_i), .wb_wdat(wb_dat_i), .wb_ack(wb_ack_o),
		.wb_rdat(wb_dat_o));

	task automatic cy(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cy

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host_u.xfer(1'b1, a, d, rdat);
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		host_u.xfer(1'b0, a, 32'h0, rdat);
		chk(rdat, exp);
	endtask : rc

	task automatic pulse(input int i);
		evt_status[i] <= 1'b1;
		cy(3);
		evt_status[i] <= 1'b0;
		cy(3);
	endtask : pulse

	task automatic final_report();
		$display("checks=%0d failures=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report

	initial begin
		for (int k = 0; k < 22; k++) begin
			tele[8*k+:8] <= 8'(k + 11);
		end
		cy(20);
		srst <= 1'b0;
		cy(1);
		wr(fer_pkg::ADR_CTRL, 32'h1);
		cy(3);
		for (int k = 0; k < 10; k++) begin
			{main_supply_enable_n, input_power_ok} <= pins[k];
			cy(8);
		end
		rc(fer_pkg::ADR_CYCLES, 32'h0001_0002);
		rc(fer_pkg::ADR_STATUS, 32'h0000_0300);
		wr(fer_pkg::ADR_IRQ_MASK, 32'h2);
		for (int i = 0; i < 10; i++) begin
			repeat (pulses[i]) pulse(i);
		end
		rc(fer_pkg::ADR_EVT_LO, 32'h8765_432F);
		rc(fer_pkg::ADR_EVT_HI, 32'h0000_00A9);
		rc(fer_pkg::ADR_STATUS, 32'h0000_0305);
		rc(fer_pkg::ADR_IRQ_STAT, 32'h3);
		chk({31'h0, irq}, 32'h1);
		wr(fer_pkg::ADR_IRQ_STAT, 32'h2);
		cy(2);
		chk({31'h0, irq}, 32'h0);
		rc(fer_pkg::ADR_IRQ_STAT, 32'h1);
		wr(fer_pkg::ADR_IRQ_MASK, 32'h1);
		cy(2);
		chk({31'h0, irq}, 32'h1);
		wr(fer_pkg::ADR_IRQ_STAT, 32'h1);
		cy(2);
		chk({31'h0, irq}, 32'h0);
		wr(8'h40, 32'hFFFF_FFFF);
		rc(8'h40, 32'h0);
		wr(fer_pkg::ADR_LOG_PTR, 32'h0000_0007);
		for (int k = 7; k < 38; k++) begin
			e = k > 32 ? cnt_byte[k] : k > 10 ? 8'(k) :
				8'(k == 7) | 8'(k == 9) << 1;
			rc(fer_pkg::ADR_LOG_DATA, {24'h0, e});
		end
		wr(fer_pkg::ADR_LOG_PTR, 32'h0000_0049);
		rc(fer_pkg::ADR_LOG_DATA, 32'h55);
		wr(fer_pkg::ADR_LOG_PTR, 32'h0000_00BD);
		rc(fer_pkg::ADR_LOG_DATA, 32'h0);
		rc(fer_pkg::ADR_LOG_PTR, 32'h0);
		srst <= 1'b1;
		cy(2);
		srst <= 1'b0;
		cy(1);
		rc(fer_pkg::ADR_EVT_LO, 32'h0);
		wr(fer_pkg::ADR_CTRL, 32'h2);
		cy(3);
		rc(fer_pkg::ADR_EVT_LO, 32'h0065_432F);
		rc(fer_pkg::ADR_STATUS, 32'h0000_0305);
		final_report();
	end
endmodule : tb
